//--- pipelined_sram.sv
`timescale 1ns/1ps
module pipelined_sram #(
   parameter int ADDR_W = sram_pkg::ADDR_BITS,
   parameter int LANES = sram_pkg::LANES,
   parameter int LANE_W = sram_pkg::LANE_BITS
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read_not_write,
   input wire logic burst_step_or_load,
   input wire logic select_low_a,
   input wire logic select_low_b,
   input wire logic select_pair,
   input wire logic clock_suspend_n,
   input wire logic [LANES-1:0] lane_write_select_n,
   input wire logic burst_order_select,
   input wire logic output_enable_n,
   input wire logic [LANES*LANE_W-1:0] data_in,
   output logic [LANES*LANE_W-1:0] data_out,
   output logic data_oe
);

   localparam int DW = LANES * LANE_W;
   localparam int BB = sram_pkg::BURST_BITS;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [DW-1:0] mem [2**ADDR_W];
   sram_pkg::op_e s1_op, next_s1_op, s2_op, next_s2_op;
   logic [ADDR_W-1:0] s1_addr, next_s1_addr, s2_addr, next_s2_addr;
   logic [LANES-1:0] s1_lanes, next_s1_lanes, s2_lanes, next_s2_lanes;
   logic [BB-1:0] burst_base, next_burst_base, burst_count, next_burst_count;
   logic [BB-1:0] burst_low;
   logic bus_drive, next_bus_drive;
   logic [DW-1:0] next_data_out;
   logic selected;
   logic edge_en;
   logic buf_in_ready, buf_out_valid;
   logic [DW-1:0] buf_out_data;

   assign selected = !select_low_a && !select_low_b && select_pair;
   assign edge_en = !clock_suspend_n && buf_in_ready;
   assign data_oe = bus_drive && !output_enable_n;

   // ------------------------------------------------------------
   // Read data buffer
   // ------------------------------------------------------------
   two_entry_buffer #(.WIDTH(DW)) read_buffer (
      .clk(clk),
      .reset(reset),
      .in_valid(edge_en && s1_op == sram_pkg::OP_READ),
      .in_ready(buf_in_ready),
      .in_data(mem[s1_addr]),
      .out_valid(buf_out_valid),
      .out_ready(edge_en && s2_op == sram_pkg::OP_READ),
      .out_data(buf_out_data)
   );

   // ------------------------------------------------------------
   // Pipeline next state
   // ------------------------------------------------------------
   always_comb begin
      next_s1_op = s1_op;
      next_s1_addr = s1_addr;
      next_s1_lanes = s1_lanes;
      next_s2_op = s2_op;
      next_s2_addr = s2_addr;
      next_s2_lanes = s2_lanes;
      next_burst_base = burst_base;
      next_burst_count = burst_count;
      next_bus_drive = bus_drive;
      next_data_out = data_out;
      burst_low = burst_base;
      if (edge_en) begin
         if (!burst_step_or_load) begin
            if (selected) begin
               next_s1_op = read_not_write ? sram_pkg::OP_READ : sram_pkg::OP_WRITE;
               next_s1_addr = address;
               next_s1_lanes = lane_write_select_n;
               next_burst_base = address[BB-1:0];
               next_burst_count = sram_pkg::BURST_START;
            end else begin
               next_s1_op = sram_pkg::OP_IDLE;
            end
         end else if (s1_op != sram_pkg::OP_IDLE) begin
            next_burst_count = burst_count + sram_pkg::BURST_STEP;
            if (burst_order_select) begin
               burst_low = burst_base ^ next_burst_count;
            end else begin
               burst_low = burst_base + next_burst_count;
            end
            next_s1_addr = {s1_addr[ADDR_W-1:BB], burst_low};
            next_s1_lanes = lane_write_select_n;
         end
         next_s2_op = s1_op;
         next_s2_addr = s1_addr;
         next_s2_lanes = s1_lanes;
         next_bus_drive = (s2_op == sram_pkg::OP_READ);
         if (s2_op == sram_pkg::OP_READ && buf_out_valid) begin
            next_data_out = buf_out_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_op <= sram_pkg::OP_IDLE;
         s2_op <= sram_pkg::OP_IDLE;
         s1_addr <= '0;
         s2_addr <= '0;
         s1_lanes <= '1;
         s2_lanes <= '1;
         burst_base <= sram_pkg::BURST_START;
         burst_count <= sram_pkg::BURST_START;
         bus_drive <= 1'b0;
         data_out <= '0;
      end else begin
         s1_op <= next_s1_op;
         s2_op <= next_s2_op;
         s1_addr <= next_s1_addr;
         s2_addr <= next_s2_addr;
         s1_lanes <= next_s1_lanes;
         s2_lanes <= next_s2_lanes;
         burst_base <= next_burst_base;
         burst_count <= next_burst_count;
         bus_drive <= next_bus_drive;
         data_out <= next_data_out;
      end
   end

   // ------------------------------------------------------------
   // Array write
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset && edge_en && s2_op == sram_pkg::OP_WRITE) begin
         for (int i = 0; i < LANES; i++) begin
            if (!s2_lanes[i]) begin
               mem[s2_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_suspend_hold;
      @(posedge clk) disable iff (reset)
      clock_suspend_n |=> $stable(data_out) && $stable(bus_drive) && $stable(s1_addr);
   endproperty
   a_suspend_hold: assert property (p_suspend_hold) else $error("suspended edge changed state");

   property p_read_latency;
      @(posedge clk) disable iff (reset)
      (edge_en && !burst_step_or_load && selected && read_not_write) ##1 edge_en ##1 edge_en |=> bus_drive;
   endproperty
   a_read_latency: assert property (p_read_latency) else $error("read data not driven on time");

   property p_write_capture;
      @(posedge clk) disable iff (reset)
      (edge_en && s2_op == sram_pkg::OP_WRITE && !(|s2_lanes)) |=> mem[$past(s2_addr)] == $past(data_in);
   endproperty
   a_write_capture: assert property (p_write_capture) else $error("write data not captured");

   property p_deselect_release;
      @(posedge clk) disable iff (reset)
      (edge_en && !burst_step_or_load && !selected) ##1 edge_en ##1 edge_en |=> !bus_drive;
   endproperty
   a_deselect_release: assert property (p_deselect_release) else $error("bus not released after deselect");

   property p_back_to_back;
      @(posedge clk) disable iff (reset)
      (edge_en && !burst_step_or_load && selected) |=> s1_op != sram_pkg::OP_IDLE && s1_addr == $past(address);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("load not accepted");

   property p_composite_select;
      @(posedge clk) disable iff (reset)
      (edge_en && !burst_step_or_load && (select_low_a || select_low_b || !select_pair)) |=> s1_op == sram_pkg::OP_IDLE;
   endproperty
   a_composite_select: assert property (p_composite_select) else $error("operation started while deselected");

   property p_reset_release;
      @(posedge clk) reset |=> !data_oe;
   endproperty
   a_reset_release: assert property (p_reset_release) else $error("bus driven after reset edge");

   property p_burst_direction;
      @(posedge clk) disable iff (reset)
      (edge_en && burst_step_or_load && s1_op != sram_pkg::OP_IDLE) |=> s1_op == $past(s1_op);
   endproperty
   a_burst_direction: assert property (p_burst_direction) else $error("burst changed direction");

   property p_burst_wrap;
      @(posedge clk) disable iff (reset)
      (edge_en && !burst_step_or_load && selected) ##1 (edge_en && burst_step_or_load) [*4]
         |=> s1_addr == $past(s1_addr, 4);
   endproperty
   a_burst_wrap: assert property (p_burst_wrap) else $error("burst did not wrap after four words");

   property p_no_lane_write;
      @(posedge clk) disable iff (reset)
      (edge_en && s2_op == sram_pkg::OP_WRITE && (&s2_lanes)) |=> mem[$past(s2_addr)] == $past(mem[s2_addr]);
   endproperty
   a_no_lane_write: assert property (p_no_lane_write) else $error("write with no lane changed memory");

   property p_output_enable;
      @(posedge clk) output_enable_n |-> !data_oe;
   endproperty
   a_output_enable: assert property (p_output_enable) else $error("bus driven with output enable high");

   c_read: cover property (@(posedge clk) disable iff (reset) edge_en && s2_op == sram_pkg::OP_READ ##1 data_oe);
   c_write_read: cover property (@(posedge clk) disable iff (reset)
      s2_op == sram_pkg::OP_WRITE && s1_op == sram_pkg::OP_READ && edge_en);
   c_suspend_read: cover property (@(posedge clk) disable iff (reset) data_oe && clock_suspend_n ##1 data_oe);
   c_burst: cover property (@(posedge clk) disable iff (reset) (edge_en && burst_step_or_load) [*4]);

endmodule // pipelined_sram

//--- sram_pkg.sv
package sram_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int ADDR_BITS = 19;
   localparam int LANES = 4;
   localparam int LANE_BITS = 9;
   localparam int BURST_BITS = 2;
   localparam int BUF_ENTRIES = 2;

   // ------------------------------------------------------------
   // Pipeline operations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_IDLE = 2'h0,
      OP_READ = 2'h1,
      OP_WRITE = 2'h2
   } op_e;

   localparam logic [BURST_BITS-1:0] BURST_START = 2'h0;
   localparam logic [BURST_BITS-1:0] BURST_STEP = 2'h1;

endpackage

//--- two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer #(
   parameter int WIDTH = 36
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0] slot [2];
   logic [WIDTH-1:0] next_slot [2];
   logic [1:0] count;
   logic [1:0] next_count;
   logic push;
   logic pop;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_slot[0] = slot[0];
      next_slot[1] = slot[1];
      next_count = count;
      if (pop) begin
         next_slot[0] = slot[1];
      end
      if (push) begin
         if (count == 2'h0 || (count == 2'h1 && pop)) begin
            next_slot[0] = in_data;
         end else begin
            next_slot[1] = in_data;
         end
      end
      if (push && !pop) begin
         next_count = count + 2'h1;
      end else if (pop && !push) begin
         next_count = count - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count <= 2'h0;
         slot[0] <= '0;
         slot[1] <= '0;
      end else begin
         count <= next_count;
         slot[0] <= next_slot[0];
         slot[1] <= next_slot[1];
      end
   end

endmodule // two_entry_buffer

//--- sram_controller_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Controller side of the memory port
// ------------------------------------------------------------
// Codes of cmd: 0 load read, 1 load write, 2 advance, 3 to 5 a cycle with one enable inactive.
module sram_controller_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic clock_suspend_n,
   input wire logic [2:0] cmd,
   input wire logic [18:0] cmd_addr,
   input wire logic [35:0] cmd_data,
   output logic [18:0] address,
   output logic read_not_write,
   output logic burst_step_or_load,
   output logic select_low_a,
   output logic select_low_b,
   output logic select_pair,
   output logic [35:0] data_in
);
   logic dir_write;
   logic push;
   logic [1:0] stage_v;
   logic [35:0] stage1;
   logic [35:0] stage2;
   // The direction pin shows the opposite of the burst on advances, so it must be ignored.
   assign read_not_write = cmd == 3'h0 || (cmd == 3'h2 && dir_write);
   assign address = cmd_addr;
   assign burst_step_or_load = cmd == 3'h2;
   assign select_low_a = cmd == 3'h3;
   assign select_low_b = cmd == 3'h4;
   assign select_pair = cmd != 3'h5;
   assign push = cmd == 3'h1 || (cmd == 3'h2 && dir_write);
   // A released bus shows the inverse of the cmd_data staged two edges earlier.
   assign data_in = stage_v[1] ? stage2 : ~stage2;
   always_ff @(posedge clk) begin
      if (reset) begin
         stage_v <= 2'h0;
         dir_write <= 1'b0;
      end else if (!clock_suspend_n) begin
         stage_v <= {stage_v[0], push};
         stage1 <= cmd_data;
         stage2 <= stage1;
         if (cmd < 3'h2) dir_write <= cmd == 3'h1;
      end
   end
endmodule // sram_controller_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] cmd = 3'h3;
   logic [18:0] cmd_addr = 19'h0;
   logic [35:0] cmd_data = 36'h0;
   logic [3:0] lane_write_select_n = 4'hf;
   logic clock_suspend_n = 1'b0;
   logic burst_order_select = 1'b0;
   logic output_enable_n = 1'b0;
   logic [18:0] address;
   logic read_not_write, burst_step_or_load, select_low_a, select_low_b, select_pair, data_oe;
   logic [35:0] data_in, data_out, e1_d, e2_d, e3_d, wr_d;
   logic [35:0] ref_mem [16];
   logic e1_rd = 1'b0, e2_rd = 1'b0, e3_rd = 1'b0, burst_rd = 1'b0;
   logic [3:0] burst_base = 4'h0, base, a;
   logic [1:0] burst_k = 2'h0, k;
   int errors = 0, comparisons = 0, cycles = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   sram_controller_model partner_u (.clk(clk), .reset(reset), .clock_suspend_n(clock_suspend_n), .cmd(cmd),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .address(address), .read_not_write(read_not_write),
      .burst_step_or_load(burst_step_or_load), .select_low_a(select_low_a), .select_low_b(select_low_b),
      .select_pair(select_pair), .data_in(data_in));
   pipelined_sram dut_u (.clk(clk), .reset(reset), .address(address), .read_not_write(read_not_write),
      .burst_step_or_load(burst_step_or_load), .select_low_a(select_low_a), .select_low_b(select_low_b),
      .select_pair(select_pair), .clock_suspend_n(clock_suspend_n), .lane_write_select_n(lane_write_select_n),
      .burst_order_select(burst_order_select), .output_enable_n(output_enable_n), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe));
   // ------------------------------------------------------------
   // Expected bus, two valid edges behind each command
   // ------------------------------------------------------------
   always_comb begin
      k = (cmd == 3'h2) ? burst_k + 2'h1 : 2'h0;
      base = (cmd == 3'h2) ? burst_base : cmd_addr[3:0];
      a = burst_order_select ? base ^ {2'h0, k} : {base[3:2], base[1:0] + k};
      wr_d = ref_mem[a];
      for (int i = 0; i < 4; i++)
         if (!lane_write_select_n[i]) wr_d[i*9+:9] = cmd_data[i*9+:9];
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         errors++;
         report_and_stop();
      end
      if (reset) begin
         e1_rd <= 1'b0;
         e2_rd <= 1'b0;
         e3_rd <= 1'b0;
      end else if (!clock_suspend_n) begin
         e3_rd <= e2_rd;
         e3_d <= e2_d;
         e2_rd <= e1_rd;
         e2_d <= e1_d;
         e1_rd <= cmd == 3'h0 || (cmd == 3'h2 && burst_rd);
         e1_d <= ref_mem[a];
         burst_k <= k;
         if (cmd < 3'h2) burst_base <= cmd_addr[3:0];
         if (cmd < 3'h2) burst_rd <= cmd == 3'h0;
         if (cmd == 3'h1 || (cmd == 3'h2 && !burst_rd)) ref_mem[a] <= wr_d;
      end
   end
   always @(negedge clk) begin
      if (!reset) begin
         comparisons++;
         if (data_oe !== (e3_rd && !output_enable_n) || (e3_rd && data_oe && data_out !== e3_d)) begin
            errors++;
            $display("wrong value at %0t ns: bus %b data %h", $time, data_oe, data_out);
         end
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic cyc(input logic [2:0] c, input logic [3:0] ad, input logic [35:0] d = 36'h0,
      input logic [3:0] ln = 4'h0, input logic s = 1'b0);
      @(posedge clk);
      cmd <= c;
      cmd_addr <= {15'h0, ad};
      cmd_data <= d;
      lane_write_select_n <= ln;
      clock_suspend_n <= s;
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(3'h3, 4'h0, 36'h0, 4'hf);
   endtask
   task automatic t_fill;
      for (int i = 0; i < 16; i++) cyc(3'h1, 4'(i), {9{4'(i)}});
      idle(3);
      for (int i = 0; i < 8; i++) begin
         cyc(3'h0, 4'(i));
         cyc(3'h1, 4'(i + 8), ~{9{4'(i)}});
      end
      idle(3);
      for (int i = 8; i < 16; i++) cyc(3'h0, 4'(i));
      idle(3);
      $display("test fill done");
   endtask
   task automatic t_lanes;
      for (int i = 0; i < 6; i++) cyc(3'h1, 4'(i), 36'h0, i < 4 ? ~(4'h1 << i) : (i == 4 ? 4'hf : 4'h3));
      idle(3);
      for (int i = 0; i < 6; i++) cyc(3'h0, 4'(i));
      idle(3);
      $display("test lanes done");
   endtask
   task automatic t_desel;
      for (int c = 3; c < 6; c++) begin
         cyc(3'(c), 4'h7);
         cyc(3'h0, 4'h7);
      end
      cyc(3'h1, 4'h2, 36'h123456789);
      cyc(3'h5, 4'h2);
      cyc(3'h1, 4'h3, 36'hfedcba987);
      idle(3);
      cyc(3'h0, 4'h2);
      cyc(3'h0, 4'h3);
      idle(3);
      $display("test deselect done");
   endtask
   task automatic t_suspend;
      cyc(3'h0, 4'h1);
      cyc(3'h0, 4'h2, 36'h0, 4'h0, 1'b1);
      cyc(3'h0, 4'h3);
      cyc(3'h1, 4'h4, 36'h5a5a5a5a5);
      cyc(3'h0, 4'h5, 36'h0, 4'h0, 1'b1);
      cyc(3'h1, 4'h6, 36'h0, 4'h0, 1'b1);
      cyc(3'h0, 4'h5);
      idle(3);
      cyc(3'h0, 4'h4);
      idle(3);
      $display("test suspend done");
   endtask
   task automatic t_burst;
      for (int o = 0; o < 2; o++) begin
         burst_order_select <= 1'(o);
         cyc(3'h0, 4'h6);
         repeat (4) cyc(3'h2, 4'h0);
         cyc(3'h1, 4'h9, 36'h0a0a0a0a0 + 36'(o));
         for (int j = 1; j < 4; j++) cyc(3'h2, 4'h0, {9{4'(j)}} + 36'(o));
         idle(3);
         cyc(3'h0, 4'hb);
         repeat (3) cyc(3'h2, 4'h0);
         idle(3);
      end
      $display("test burst done");
   endtask
   task automatic t_oe;
      for (int i = 0; i < 6; i++) begin
         cyc(3'h0, 4'(i));
         output_enable_n <= 1'(i);
      end
      idle(3);
      output_enable_n <= 1'b0;
      $display("test output enable done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_fill();
      t_lanes();
      t_desel();
      t_suspend();
      t_burst();
      t_oe();
      report_and_stop();
   end
endmodule // testbench
